// File: common/tmr_pkg.sv
// Constants shared by the timer front end: register offsets, field positions,
// reset values and clock select codes.
// Assumes a byte-wide register port with a three-bit word address.
// Summary of operation
// - Counter and both compare values are each held in eight-bit registers.
// - Three request sources: overflow, compare match A and compare match B.
// - All requests show in the flag register; each is gated by its mask bit.
// - Compare values are checked against the counter on each tick not blocked by a count write; equality sets the flag.
// - Counter is at its lower limit whenever its value is 0x00.
// - Counter is at its absolute maximum whenever its value is 0xFF.
// - Top of count is 0xFF or compare value A, chosen by mode.
// - Clock select zero gives no ticks; the counter stays still.
// - Clock select one ticks the counter at every system clock.
// - Prescaled ticks at system clock divided by 8, 64, 256 and 1024.
// - Prescaler runs freely; changing clock select never resets it.
// - First prescaled count comes 1 to N+1 cycles after enabling.
// - Software can reset the prescaler to align ticks with the program.
// - Count pin passes a clock-high latch then rising-edge flops before edge detect.
// - Select 7 ticks on rising pin edges, select 6 on falling edges.
// - Counter updates 3.5 to 4.5 cycles after an active pin edge.
// - The external count source is never divided by the prescaler.
package tmr_pkg;

	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	localparam logic [2:0] ADDR_COUNT = 3'h0;
	localparam logic [2:0] ADDR_CMP_A = 3'h1;
	localparam logic [2:0] ADDR_CMP_B = 3'h2;
	localparam logic [2:0] ADDR_CTRL_B = 3'h3;
	localparam logic [2:0] ADDR_FLAGS = 3'h4;
	localparam logic [2:0] ADDR_MASK = 3'h5;

	// Control register fields.
	localparam int CTRL_CS_LSB = 0;
	localparam int CTRL_TOP_SEL_BIT = 3;
	localparam int CTRL_PRESC_RST_BIT = 7;

	// Flag and mask bit positions.
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMP_A_BIT = 1;
	localparam int FLAG_CMP_B_BIT = 2;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] BOTTOM_VALUE = 8'h00;
	localparam logic [7:0] MAX_VALUE = 8'hFF;

	typedef enum logic [2:0] {
		CS_STOP = 3'h0,
		CS_DIRECT = 3'h1,
		CS_DIV8 = 3'h2,
		CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4,
		CS_DIV1024 = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} clock_select_t;

	// Prescaler tap widths: a tap fires when this many low bits are all ones.
	localparam int TAP_BITS_8 = 3;
	localparam int TAP_BITS_64 = 6;
	localparam int TAP_BITS_256 = 8;
	localparam int TAP_BITS_1024 = 10;
	localparam int PRESC_W_MIN = 10;

endpackage

// File: rtl/pin_edge_detect.sv
// Synchroniser and edge detector for the external count pin.
// Assumes the pin may change at any time relative to mclk.
`timescale 1ns/1ns
module pin_edge_detect (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic rise_r,
	output logic fall_r
);
	logic latch_q;
	logic sync_r;
	logic sync_nxt;
	logic prev_r;
	logic prev_nxt;
	logic rise_nxt;
	logic fall_nxt;

	// Transparent while the clock is high, so the sample is settled by the
	// next rising edge; this half cycle is where the 3.5 figure comes from.
	// The update is non-blocking so the flop below always takes the value
	// held through the low phase, not one that opens on the same edge.
	always_latch begin
		if (mclk) begin
			latch_q <= pin_in;
		end
	end

	always_comb begin
		sync_nxt = latch_q;
		prev_nxt = sync_r;
		rise_nxt = sync_r & ~prev_r;
		fall_nxt = ~sync_r & prev_r;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sync_r <= 1'b0;
			prev_r <= 1'b0;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end else begin
			sync_r <= sync_nxt;
			prev_r <= prev_nxt;
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
		end
	end

endmodule

// File: rtl/timer_front.sv
// Timer front end: clock select, free-running prescaler, external count
// input, an up-counter with two compare units and the three request flags.
// Assumes a register port with one-cycle strobes and read data a cycle later.
`timescale 1ns/1ns
module timer_front #(
	parameter int PRESC_W = 10
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [tmr_pkg::ADDR_W-1:0] addr,
	input wire logic [tmr_pkg::DATA_W-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [tmr_pkg::DATA_W-1:0] rdata_r,
	input wire logic external_count_pin,
	output logic timer_tick_r,
	output logic overflow_req_r,
	output logic compare_a_req_r,
	output logic compare_b_req_r,
	output logic at_bottom_r,
	output logic at_max_r,
	output logic at_top_r
);
	import tmr_pkg::*;

	if (PRESC_W < PRESC_W_MIN) begin : g_check
		$error("Prescaler must be at least ten bits wide.");
	end

	logic [7:0] count_value_r, count_value_nxt;
	logic [7:0] compare_value_a_r, compare_value_a_nxt;
	logic [7:0] compare_value_b_r, compare_value_b_nxt;
	logic [7:0] timer_control_b_r, timer_control_b_nxt;
	logic [2:0] timer_flag_register_r, timer_flag_register_nxt;
	logic [2:0] timer_mask_register_r, timer_mask_register_nxt;
	logic [PRESC_W-1:0] presc_r, presc_nxt;
	logic block_r, block_nxt;
	logic [7:0] rdata_nxt;
	logic timer_tick_nxt;
	logic overflow_req_nxt, compare_a_req_nxt, compare_b_req_nxt;
	logic at_bottom_nxt, at_max_nxt, at_top_nxt;

	logic ext_rise, ext_fall;
	clock_select_t clock_select_field;
	logic [7:0] top_value;
	logic wr_count;
	logic set_ovf, set_cmp_a, set_cmp_b;
	logic [2:0] flag_set, flag_clr;

	pin_edge_detect u_edge (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin_in(external_count_pin),
		.rise_r(ext_rise),
		.fall_r(ext_fall)
	);

	assign clock_select_field = clock_select_t'(timer_control_b_r[CTRL_CS_LSB +: 3]);

	// Prescaler: free running, touched only by its own reset strobe.
	always_comb begin
		presc_nxt = presc_r + {{(PRESC_W-1){1'b0}}, 1'b1};
		if (wr_stb && addr == ADDR_CTRL_B && wdata[CTRL_PRESC_RST_BIT]) begin
			presc_nxt = '0;
		end
	end

	// Tick selection. The tick is registered, so a prescaled tap gives its
	// first count somewhere between 1 and N+1 cycles after enabling.
	always_comb begin
		timer_tick_nxt = 1'b0;
		case (clock_select_field)
			CS_STOP: timer_tick_nxt = 1'b0;
			CS_DIRECT: timer_tick_nxt = 1'b1;
			CS_DIV8: timer_tick_nxt = &presc_r[TAP_BITS_8-1:0];
			CS_DIV64: timer_tick_nxt = &presc_r[TAP_BITS_64-1:0];
			CS_DIV256: timer_tick_nxt = &presc_r[TAP_BITS_256-1:0];
			CS_DIV1024: timer_tick_nxt = &presc_r[TAP_BITS_1024-1:0];
			CS_EXT_FALL: timer_tick_nxt = ext_fall;
			CS_EXT_RISE: timer_tick_nxt = ext_rise;
			default: timer_tick_nxt = 1'b0;
		endcase
	end

	assign top_value = timer_control_b_r[CTRL_TOP_SEL_BIT] ? compare_value_a_r
		: MAX_VALUE;
	assign wr_count = wr_stb && addr == ADDR_COUNT;

	// Counter, compare units and flag sources. A write to the count takes
	// priority and blocks compare matches for the following tick, so a
	// compare value equal to the new count does not fire on enable.
	always_comb begin
		count_value_nxt = count_value_r;
		block_nxt = block_r;
		set_ovf = 1'b0;
		set_cmp_a = 1'b0;
		set_cmp_b = 1'b0;
		if (timer_tick_r) begin
			set_ovf = count_value_r == MAX_VALUE;
			set_cmp_a = !block_r && count_value_r == compare_value_a_r;
			set_cmp_b = !block_r && count_value_r == compare_value_b_r;
			block_nxt = 1'b0;
			if (count_value_r == top_value) begin
				count_value_nxt = BOTTOM_VALUE;
			end else begin
				count_value_nxt = count_value_r + 8'h01;
			end
		end
		if (wr_count) begin
			count_value_nxt = wdata;
			block_nxt = 1'b1;
		end
	end

	// Register writes and flag handling; a hardware set beats a clear.
	always_comb begin
		compare_value_a_nxt = compare_value_a_r;
		compare_value_b_nxt = compare_value_b_r;
		timer_control_b_nxt = timer_control_b_r;
		timer_mask_register_nxt = timer_mask_register_r;
		flag_clr = 3'h0;
		if (wr_stb) begin
			if (addr == ADDR_CMP_A) begin
				compare_value_a_nxt = wdata;
			end else if (addr == ADDR_CMP_B) begin
				compare_value_b_nxt = wdata;
			end else if (addr == ADDR_CTRL_B) begin
				// The prescaler reset bit is a strobe and never stores.
				timer_control_b_nxt = wdata & 8'h7F;
			end else if (addr == ADDR_FLAGS) begin
				flag_clr = wdata[2:0];
			end else if (addr == ADDR_MASK) begin
				timer_mask_register_nxt = wdata[2:0];
			end
		end
		flag_set = 3'h0;
		flag_set[FLAG_OVF_BIT] = set_ovf;
		flag_set[FLAG_CMP_A_BIT] = set_cmp_a;
		flag_set[FLAG_CMP_B_BIT] = set_cmp_b;
		timer_flag_register_nxt = (timer_flag_register_r & ~flag_clr) | flag_set;
	end

	// Read port and status outputs.
	always_comb begin
		rdata_nxt = 8'h00;
		if (rd_stb) begin
			if (addr == ADDR_COUNT) begin
				rdata_nxt = count_value_r;
			end else if (addr == ADDR_CMP_A) begin
				rdata_nxt = compare_value_a_r;
			end else if (addr == ADDR_CMP_B) begin
				rdata_nxt = compare_value_b_r;
			end else if (addr == ADDR_CTRL_B) begin
				rdata_nxt = timer_control_b_r;
			end else if (addr == ADDR_FLAGS) begin
				rdata_nxt = {5'h00, timer_flag_register_r};
			end else if (addr == ADDR_MASK) begin
				rdata_nxt = {5'h00, timer_mask_register_r};
			end
		end
		overflow_req_nxt = timer_flag_register_r[FLAG_OVF_BIT]
			& timer_mask_register_r[FLAG_OVF_BIT];
		compare_a_req_nxt = timer_flag_register_r[FLAG_CMP_A_BIT]
			& timer_mask_register_r[FLAG_CMP_A_BIT];
		compare_b_req_nxt = timer_flag_register_r[FLAG_CMP_B_BIT]
			& timer_mask_register_r[FLAG_CMP_B_BIT];
		at_bottom_nxt = count_value_nxt == BOTTOM_VALUE;
		at_max_nxt = count_value_nxt == MAX_VALUE;
		at_top_nxt = count_value_nxt == top_value;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count_value_r <= RESET_BYTE;
			compare_value_a_r <= RESET_BYTE;
			compare_value_b_r <= RESET_BYTE;
			timer_control_b_r <= RESET_BYTE;
			timer_flag_register_r <= 3'h0;
			timer_mask_register_r <= 3'h0;
			presc_r <= '0;
			block_r <= 1'b0;
			rdata_r <= 8'h00;
			timer_tick_r <= 1'b0;
			overflow_req_r <= 1'b0;
			compare_a_req_r <= 1'b0;
			compare_b_req_r <= 1'b0;
			at_bottom_r <= 1'b1;
			at_max_r <= 1'b0;
			at_top_r <= 1'b0;
		end else begin
			count_value_r <= count_value_nxt;
			compare_value_a_r <= compare_value_a_nxt;
			compare_value_b_r <= compare_value_b_nxt;
			timer_control_b_r <= timer_control_b_nxt;
			timer_flag_register_r <= timer_flag_register_nxt;
			timer_mask_register_r <= timer_mask_register_nxt;
			presc_r <= presc_nxt;
			block_r <= block_nxt;
			rdata_r <= rdata_nxt;
			timer_tick_r <= timer_tick_nxt;
			overflow_req_r <= overflow_req_nxt;
			compare_a_req_r <= compare_a_req_nxt;
			compare_b_req_r <= compare_b_req_nxt;
			at_bottom_r <= at_bottom_nxt;
			at_max_r <= at_max_nxt;
			at_top_r <= at_top_nxt;
		end
	end

endmodule

// File: sim/timer_front_assertions.sv
// Checker for the timer front end, bound to its ports.
// Assumes control and mask change only through register writes.
`timescale 1ns/1ns
module timer_front_assertions (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [tmr_pkg::ADDR_W-1:0] addr,
	input wire logic [tmr_pkg::DATA_W-1:0] wdata,
	input wire logic wr_stb,
	input wire logic external_count_pin,
	input wire logic timer_tick_r,
	input wire logic overflow_req_r,
	input wire logic compare_a_req_r,
	input wire logic compare_b_req_r,
	input wire logic at_bottom_r,
	input wire logic at_max_r,
	input wire logic at_top_r
);
	import tmr_pkg::*;
	logic [3:0] ctl_r, ctl_nxt;
	logic [2:0] msk_r, msk_nxt;
	logic [2:0] cs;
	assign cs = ctl_r[2:0];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Shadow copies of control and mask, taken from the write traffic.
	always_comb begin
		ctl_nxt = (wr_stb && addr == ADDR_CTRL_B) ? wdata[3:0] : ctl_r;
		msk_nxt = (wr_stb && addr == ADDR_MASK) ? wdata[2:0] : msk_r;
		if (!rst_n) begin
			ctl_nxt = 4'h0;
			msk_nxt = 3'h0;
		end
	end
	always_ff @(posedge mclk) begin
		ctl_r <= ctl_nxt;
		msk_r <= msk_nxt;
	end
	property p_stop;
		cs == CS_STOP && $past(cs) == CS_STOP |-> !timer_tick_r;
	endproperty
	a_stop: assert property (p_stop) else $error("tick while stopped");
	property p_direct;
		cs == CS_DIRECT && $past(cs) == CS_DIRECT |-> timer_tick_r;
	endproperty
	a_direct: assert property (p_direct) else $error("direct tick missing");
	property p_rise;
		cs == CS_EXT_RISE && $past(cs) == CS_EXT_RISE && $rose(external_count_pin)
			|-> ##[1:4] timer_tick_r;
	endproperty
	a_rise: assert property (p_rise) else $error("pin edge gave no tick");
	property p_div8;
		timer_tick_r && cs == CS_DIV8 && $past(cs) == CS_DIV8 |=>
			(!timer_tick_r || cs != CS_DIV8) [*7] ##1 (timer_tick_r || cs != CS_DIV8);
	endproperty
	a_div8: assert property (p_div8) else $error("divide by 8 spacing wrong");
	property p_mask;
		({compare_b_req_r, compare_a_req_r, overflow_req_r} & ~($past(msk_r) | msk_r)) == 3'h0;
	endproperty
	a_mask: assert property (p_mask) else $error("request with mask clear");
	property p_wrap;
		at_top_r && timer_tick_r |=> at_bottom_r;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap to zero at top");
	property p_max;
		!ctl_r[3] && !$past(ctl_r[3]) |-> at_top_r == at_max_r;
	endproperty
	a_max: assert property (p_max) else $error("top differs from max");
	property p_ovf;
		at_max_r && timer_tick_r && msk_r[0] |-> ##2 overflow_req_r;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow request missing");
endmodule

bind timer_front timer_front_assertions i_timer_front_assertions (.mclk(mclk), .rst_n(rst_n),
	.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .external_count_pin(external_count_pin),
	.timer_tick_r(timer_tick_r), .overflow_req_r(overflow_req_r),
	.compare_a_req_r(compare_a_req_r), .compare_b_req_r(compare_b_req_r),
	.at_bottom_r(at_bottom_r), .at_max_r(at_max_r), .at_top_r(at_top_r));

// File: sim/count_source.sv
// Model of the external count source: a square wave unrelated to mclk.
// Assumes the bench raises run only after the clock select is settled.
`timescale 1ns/1ns
module count_source #(
	parameter int HALF_NS = 23
) (
	input wire logic run,
	output logic pin
);
	// The pin holds its level while stopped, so a later enable sees it stable.
	initial begin
		pin = 1'b0;
		forever begin
			wait (run);
			#(HALF_NS) pin = ~pin;
		end
	end
endmodule

// File: sim/timer_front_bench.sv
// Self-checking bench for the timer front end.
// Assumes the count source model drives the pin with no relation to mclk.
`timescale 1ns/1ns
module timer_front_bench;
	import tmr_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic run = 1'b0;
	logic pin;
	logic [7:0] rdata_r;
	logic tick, ovf, req_a, req_b, bot, mx, top;
	int n_errors = 0, n_tests = 0, cyc = 0, rises = 0, falls = 0, k, r0, f0;
	int div[4] = '{8, 64, 256, 1024};
	initial forever #5 mclk = ~mclk;
	always @(posedge pin) rises++;
	always @(negedge pin) falls++;
	count_source i_count_source (.run(run), .pin(pin));
	timer_front i_timer_front (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_r(rdata_r), .external_count_pin(pin),
		.timer_tick_r(tick), .overflow_req_r(ovf), .compare_a_req_r(req_a),
		.compare_b_req_r(req_b), .at_bottom_r(bot), .at_max_r(mx), .at_top_r(top));
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr_stb <= w;
		rd_stb <= !w;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		#1 if (!w) chk("rdata", {8'h00, rdata_r}, {8'h00, d});
	endtask
	task automatic wait_hi(ref logic s);
		k = 0;
		do begin
			@(posedge mclk);
			#1 k++;
		end while (s !== 1'b1 && k < 3000);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk("bottom", 16'(bot), 16'h1);
		for (int a = 0; a < 8; a++)
			acc(0, 3'(a), 8'h00);
		acc(1, ADDR_CMP_A, 8'hA5);
		acc(1, ADDR_CMP_B, 8'h5A);
		acc(1, ADDR_COUNT, 8'h3C);
		acc(1, 3'h6, 8'hFF);
		repeat (20) @(posedge mclk);
		acc(0, ADDR_CMP_A, 8'hA5);
		acc(0, ADDR_CMP_B, 8'h5A);
		acc(0, ADDR_COUNT, 8'h3C);
		acc(0, 3'h6, 8'h00);
		$display("test registers done");
		acc(1, ADDR_COUNT, 8'hFF);
		chk("max", 16'(mx), 16'h1);
		chk("top", 16'(top), 16'h1);
		acc(1, ADDR_MASK, 8'h07);
		acc(1, ADDR_CMP_A, 8'h10);
		acc(1, ADDR_CMP_B, 8'h20);
		acc(1, ADDR_COUNT, 8'h00);
		acc(1, ADDR_CTRL_B, 8'h01);
		repeat (10) @(posedge mclk);
		acc(1, ADDR_CTRL_B, 8'h00);
		acc(0, ADDR_COUNT, 8'h0C);
		acc(1, ADDR_CTRL_B, 8'h01);
		wait_hi(ovf);
		acc(1, ADDR_CTRL_B, 8'h00);
		acc(0, ADDR_FLAGS, 8'h07);
		chk("reqs", 16'({req_b, req_a, ovf}), 16'h7);
		acc(1, ADDR_MASK, 8'h00);
		repeat (3) @(posedge mclk);
		chk("masked", 16'({req_b, req_a, ovf}), 16'h0);
		acc(1, ADDR_FLAGS, 8'h07);
		acc(0, ADDR_FLAGS, 8'h00);
		acc(1, ADDR_CMP_A, 8'h05);
		acc(1, ADDR_COUNT, 8'h00);
		acc(1, ADDR_CTRL_B, 8'h09);
		repeat (11) @(posedge mclk);
		acc(1, ADDR_CTRL_B, 8'h08);
		acc(0, ADDR_COUNT, 8'h01);
		$display("test direct done");
		for (int i = 0; i < 4; i++) begin
			acc(1, ADDR_CTRL_B, 8'(i + 2));
			wait_hi(tick);
			chk("first", 16'(k <= div[i] + 1), 16'h1);
			wait_hi(tick);
			chk("gap", 16'(k), 16'(div[i]));
			acc(1, ADDR_CTRL_B, 8'h00);
		end
		acc(1, ADDR_CTRL_B, 8'h82);
		wait_hi(tick);
		chk("aligned", 16'(k), 16'h8);
		acc(1, ADDR_CTRL_B, 8'h00);
		$display("test prescaler done");
		for (int m = 0; m < 2; m++) begin
			acc(1, ADDR_COUNT, 8'h00);
			acc(1, ADDR_CTRL_B, m ? 8'h06 : 8'h07);
			r0 = rises;
			f0 = falls;
			run <= 1'b1;
			repeat (40) @(posedge mclk);
			run <= 1'b0;
			repeat (10) @(posedge mclk);
			acc(1, ADDR_CTRL_B, 8'h00);
			acc(0, ADDR_COUNT, 8'(m ? falls - f0 : rises - r0));
		end
		$display("test external done");
		test_done();
	end
endmodule
